/* File: include/plut_regs.vh */
// Register offsets, field positions and codes of the palette access block
`ifndef PLUT_REGS_VH
`define PLUT_REGS_VH

`define PLUT_ADDR_MASK      16'h03c6
`define PLUT_ADDR_STATE     16'h03c7
`define PLUT_ADDR_RPTR      16'h03c7
`define PLUT_ADDR_WPTR      16'h03c8
`define PLUT_ADDR_DATA      16'h03c9

`define PLUT_STATE_WPTR     2'h0
`define PLUT_STATE_RPTR     2'h2
`define PLUT_STATE_LSB      0
`define PLUT_STATE_MSB      1

`define PLUT_PH_RED         2'h0
`define PLUT_PH_GREEN       2'h1
`define PLUT_PH_BLUE        2'h2

`define PLUT_RST_MASK       8'hff
`define PLUT_RST_PTR        8'h00
`define PLUT_RST_BYTE       8'h00
`define PLUT_RST_RGB        24'h000000

`endif

/* File: src/plut_access.v */
// Host front end of the colour look-up table with pixel masking and lookup
`timescale 1ns/1ps
`include "plut_regs.vh"
module plut_access #(
    parameter ALT_AW = 3
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Host byte I/O
    input  wire [15:0] io_addr,
    input  wire        io_rd,
    input  wire        io_wr,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output wire        io_hit,
    // Configuration
    input  wire        alt_set_sel,
    input  wire        direct_mode,
    // Pixel path
    input  wire [7:0]  pix_in,
    input  wire [23:0] pix_direct,
    output reg  [23:0] pix_rgb
);
    // Host-visible registers and their next values
    reg  [7:0]  mask_r;
    reg  [7:0]  mask_nxt;
    reg  [7:0]  rptr_r;
    reg  [7:0]  rptr_nxt;
    reg  [7:0]  wptr_r;
    reg  [7:0]  wptr_nxt;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;

    // Colour-byte sequencers, one per direction
    reg  [1:0]  rphase_r;
    reg  [1:0]  rphase_nxt;
    reg  [1:0]  wphase_r;
    reg  [1:0]  wphase_nxt;

    // Red and green of a pending write; table untouched until blue
    reg  [7:0]  stage_red_r;
    reg  [7:0]  stage_red_nxt;
    reg  [7:0]  stage_grn_r;
    reg  [7:0]  stage_grn_nxt;

    // Next values of the registered outputs
    reg  [7:0]  rd_byte;
    reg  [7:0]  rdata_nxt;
    reg  [23:0] pix_nxt;

    // Address decode
    wire        sel_mask  = (io_addr == `PLUT_ADDR_MASK);
    wire        sel_state = (io_addr == `PLUT_ADDR_STATE);
    wire        sel_wptr  = (io_addr == `PLUT_ADDR_WPTR);
    wire        sel_data  = (io_addr == `PLUT_ADDR_DATA);

    // Qualified host accesses
    wire        mask_wr   = io_wr & sel_mask;
    wire        rptr_wr   = io_wr & sel_state;
    wire        wptr_wr   = io_wr & sel_wptr;
    wire        ptr_wr    = rptr_wr | wptr_wr;
    wire        data_rd   = io_rd & sel_data;
    wire        data_wr   = io_wr & sel_data;
    wire        wr_commit = data_wr & (wphase_r == `PLUT_PH_BLUE);

    // Table read data
    wire [23:0] std_rd_rgb;
    wire [23:0] std_pix_rgb;
    wire [23:0] alt_rd_rgb;
    wire [23:0] rd_rgb;
    wire [7:0]  pix_index;

    assign io_hit    = sel_mask | sel_state | sel_wptr | sel_data;
    assign pix_index = pix_in & mask_r;

    // Standard 256-entry table
    plut_entry_ram #(.AW(8), .DW(24)) u_std (
        .clk_sys   (clk_sys),
        .wr_en     (wr_commit & ~alt_set_sel),
        .wr_addr   (wptr_r),
        .wr_data   ({stage_red_r, stage_grn_r, io_wdata}),
        .rd_addr_a (rptr_r),
        .rd_data_a (std_rd_rgb),
        .rd_addr_b (pix_index),
        .rd_data_b (std_pix_rgb)
    );

    // Alternate cursor-colour set
    plut_entry_ram #(.AW(ALT_AW), .DW(24)) u_alt (
        .clk_sys   (clk_sys),
        .wr_en     (wr_commit & alt_set_sel),
        .wr_addr   (wptr_r[ALT_AW-1:0]),
        .wr_data   ({stage_red_r, stage_grn_r, io_wdata}),
        .rd_addr_a (rptr_r[ALT_AW-1:0]),
        .rd_data_a (alt_rd_rgb),
        .rd_addr_b (pix_index[ALT_AW-1:0]),
        .rd_data_b ()
    );

    assign rd_rgb = alt_set_sel ? alt_rd_rgb : std_rd_rgb;

    // Mask register
    always @* begin
        mask_nxt = mask_r;
        if (mask_wr) begin
            mask_nxt = io_wdata;
        end
    end

    // Which pointer the host wrote last
    always @* begin
        state_nxt = state_r;
        if (rptr_wr) begin
            state_nxt = `PLUT_STATE_RPTR;
        end else if (wptr_wr) begin
            state_nxt = `PLUT_STATE_WPTR;
        end
    end

    // Read pointer and read sequencer
    always @* begin
        rptr_nxt   = rptr_r;
        rphase_nxt = rphase_r;
        if (ptr_wr) begin
            // Either pointer write restarts reads at red
            rphase_nxt = `PLUT_PH_RED;
            if (rptr_wr) begin
                rptr_nxt = io_wdata;
            end
        end else if (data_rd) begin
            case (rphase_r)
                `PLUT_PH_RED: begin
                    rphase_nxt = `PLUT_PH_GREEN;
                end
                `PLUT_PH_GREEN: begin
                    rphase_nxt = `PLUT_PH_BLUE;
                end
                default: begin
                    // Third byte read: step to the next entry
                    rphase_nxt = `PLUT_PH_RED;
                    rptr_nxt   = rptr_r + 8'h01;
                end
            endcase
        end
    end

    // Write pointer, write sequencer and staging
    always @* begin
        wptr_nxt      = wptr_r;
        wphase_nxt    = wphase_r;
        stage_red_nxt = stage_red_r;
        stage_grn_nxt = stage_grn_r;
        if (ptr_wr) begin
            // Staged bytes of a cut triplet are dropped
            wphase_nxt = `PLUT_PH_RED;
            if (wptr_wr) begin
                wptr_nxt = io_wdata;
            end
        end else if (data_wr) begin
            case (wphase_r)
                `PLUT_PH_RED: begin
                    stage_red_nxt = io_wdata;
                    wphase_nxt    = `PLUT_PH_GREEN;
                end
                `PLUT_PH_GREEN: begin
                    stage_grn_nxt = io_wdata;
                    wphase_nxt    = `PLUT_PH_BLUE;
                end
                default: begin
                    // Blue commits the entry this cycle, then step
                    wphase_nxt = `PLUT_PH_RED;
                    wptr_nxt   = wptr_r + 8'h01;
                end
            endcase
        end
    end

    // Colour byte the data port returns
    always @* begin
        case (rphase_r)
            `PLUT_PH_RED:   rd_byte = rd_rgb[23:16];
            `PLUT_PH_GREEN: rd_byte = rd_rgb[15:8];
            default:        rd_byte = rd_rgb[7:0];
        endcase
    end

    // Read data holds until the next read strobe
    always @* begin
        rdata_nxt = io_rdata;
        if (io_rd) begin
            // Unmapped reads and reserved state bits give zero
            rdata_nxt = `PLUT_RST_BYTE;
            if (sel_mask) begin
                rdata_nxt = mask_r;
            end else if (sel_state) begin
                rdata_nxt[`PLUT_STATE_MSB:`PLUT_STATE_LSB] = state_r;
            end else if (sel_wptr) begin
                rdata_nxt = wptr_r;
            end else if (sel_data) begin
                rdata_nxt = rd_byte;
            end
        end
    end

    // Lookup in indexed mode, pass-through in direct mode
    // Alternate set only serves host reads and writes, never pixels
    always @* begin
        if (direct_mode) begin
            pix_nxt = pix_direct;
        end else begin
            pix_nxt = std_pix_rgb;
        end
    end

    // Mask register flop
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_r <= `PLUT_RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Pointer flops
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rptr_r <= `PLUT_RST_PTR;
            wptr_r <= `PLUT_RST_PTR;
        end else begin
            rptr_r <= rptr_nxt;
            wptr_r <= wptr_nxt;
        end
    end

    // Last-pointer indicator flop
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= `PLUT_STATE_WPTR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Sequencer flops
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rphase_r <= `PLUT_PH_RED;
            wphase_r <= `PLUT_PH_RED;
        end else begin
            rphase_r <= rphase_nxt;
            wphase_r <= wphase_nxt;
        end
    end

    // Staging flops
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stage_red_r <= `PLUT_RST_BYTE;
            stage_grn_r <= `PLUT_RST_BYTE;
        end else begin
            stage_red_r <= stage_red_nxt;
            stage_grn_r <= stage_grn_nxt;
        end
    end

    // Registered read data
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            io_rdata <= `PLUT_RST_BYTE;
        end else begin
            io_rdata <= rdata_nxt;
        end
    end

    // Registered pixel colour
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pix_rgb <= `PLUT_RST_RGB;
        end else begin
            pix_rgb <= pix_nxt;
        end
    end
endmodule // plut_access

/* File: src/plut_entry_ram.v */
// Colour table storage: one synchronous write port, two asynchronous read ports
`timescale 1ns/1ps
module plut_entry_ram #(
    parameter AW = 8,
    parameter DW = 24
) (
    // Clock
    input  wire          clk_sys,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read ports
    input  wire [AW-1:0] rd_addr_a,
    output wire [DW-1:0] rd_data_a,
    input  wire [AW-1:0] rd_addr_b,
    output wire [DW-1:0] rd_data_b
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule // plut_entry_ram

/* File: test/plut_access_bench.sv */
// Self-checking testbench of the palette access block
`timescale 1ns/1ps
module plut_access_bench;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         alt_set_sel = 1'b0;
    reg         direct_mode = 1'b0;
    reg  [7:0]  pix_in = 8'h00;
    reg  [23:0] pix_direct = 24'h000000;
    wire [15:0] io_addr;
    wire        io_rd, io_wr, io_hit;
    wire [7:0]  io_wdata, io_rdata;
    wire [23:0] pix_rgb;
    integer     failures = 0;
    integer     tests_run = 0;
    integer     i;
    always #12.5 clk_sys = ~clk_sys;
    plut_host host (.clk_sys(clk_sys), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    plut_access dut (.clk_sys(clk_sys), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .alt_set_sel(alt_set_sel), .direct_mode(direct_mode), .pix_in(pix_in),
        .pix_direct(pix_direct), .pix_rgb(pix_rgb));
    task chk(input [23:0] seen, input [23:0] exp); begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    end endtask
    task rchk(input [15:0] a, input [7:0] exp);
        reg [7:0] b;
    begin
        host.rd(a, b);
        chk({16'h0000, b}, {16'h0000, exp});
    end endtask
    task tally_and_finish; begin
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end endtask
    task t_regs; begin
        host.wr(16'h03c8, 8'h5a);
        rchk(16'h03c7, 8'h00);
        host.wr(16'h03c8, 8'ha5);
        rchk(16'h03c8, 8'ha5);
        host.wr(16'h03c7, 8'h33);
        rchk(16'h03c7, 8'h02);
        host.wr(16'h03c6, 8'hc3);
        rchk(16'h03c6, 8'hc3);
        rchk(16'h03d0, 8'h00);
    end endtask
    task t_wrap; begin
        host.wr(16'h03c8, 8'hfe);
        for (i = 0; i < 9; i = i + 1) host.wr(16'h03c9, 8'h10 + i);
        rchk(16'h03c8, 8'h01);
        host.wr(16'h03c7, 8'hfe);
        for (i = 0; i < 9; i = i + 1) rchk(16'h03c9, 8'h10 + i);
    end endtask
    task t_part; begin
        host.wr(16'h03c8, 8'h0a);
        for (i = 0; i < 3; i = i + 1) host.wr(16'h03c9, 8'h21 + i);
        host.wr(16'h03c8, 8'h0a);
        host.wr(16'h03c9, 8'h77);
        host.wr(16'h03c9, 8'h88);
        host.wr(16'h03c7, 8'h0a);
        rchk(16'h03c9, 8'h21);
        host.wr(16'h03c8, 8'h0a);
        for (i = 0; i < 3; i = i + 1) host.wr(16'h03c9, 8'h31 + i);
        host.wr(16'h03c7, 8'h0a);
        for (i = 0; i < 3; i = i + 1) rchk(16'h03c9, 8'h31 + i);
    end endtask
    task t_pix; begin
        host.wr(16'h03c6, 8'h0a);
        pix_in = 8'hfe;
        @(negedge clk_sys);
        chk(pix_rgb, 24'h313233);
        host.wr(16'h03c6, 8'hff);
        pix_in = 8'hff;
        @(negedge clk_sys);
        chk(pix_rgb, 24'h131415);
        direct_mode = 1'b1;
        pix_direct = 24'habcdef;
        @(negedge clk_sys);
        chk(pix_rgb, 24'habcdef);
        direct_mode = 1'b0;
    end endtask
    task t_alt; begin
        alt_set_sel = 1'b1;
        host.wr(16'h03c8, 8'h09);
        for (i = 0; i < 3; i = i + 1) host.wr(16'h03c9, 8'h41 + i);
        host.wr(16'h03c7, 8'h01);
        rchk(16'h03c9, 8'h41);
        alt_set_sel = 1'b0;
    end endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        t_regs;
        t_wrap;
        t_part;
        t_pix;
        t_alt;
        tally_and_finish;
    end
    // About 125 cycles needed; 4000 allowed
    initial begin
        #100000;
        failures = failures + 1;
        tally_and_finish;
    end
endmodule // plut_access_bench

/* File: test/plut_access_monitor.sv */
// Port assertions of the palette access block
`timescale 1ns/1ps
module plut_access_monitor (
    input wire        clk_sys,
    input wire        rst_n,
    input wire [15:0] io_addr,
    input wire        io_rd,
    input wire        io_wr,
    input wire [7:0]  io_wdata,
    input wire [7:0]  io_rdata,
    input wire        io_hit,
    input wire        direct_mode,
    input wire [23:0] pix_direct,
    input wire [23:0] pix_rgb
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_hit; io_hit == (io_addr >= 16'h03c6 && io_addr <= 16'h03c9); endproperty
    a_hit: assert property (p_hit) else $error("bad decode");
    property p_unmap; io_rd && !io_hit |=> io_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !io_rd |=> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_direct; direct_mode |=> pix_rgb == $past(pix_direct); endproperty
    a_direct: assert property (p_direct) else $error("direct colour wrong");
    property p_st_r; io_wr && io_addr == 16'h03c7 ##2 io_rd && io_addr == 16'h03c7
        |=> io_rdata == 8'h02; endproperty
    a_st_r: assert property (p_st_r) else $error("state not read");
    property p_st_w; io_wr && io_addr == 16'h03c8 ##2 io_rd && io_addr == 16'h03c7
        |=> io_rdata == 8'h00; endproperty
    a_st_w: assert property (p_st_w) else $error("state not write");
    property p_wptr; io_wr && io_addr == 16'h03c8 ##2 io_rd && io_addr == 16'h03c8
        |=> io_rdata == $past(io_wdata, 3); endproperty
    a_wptr: assert property (p_wptr) else $error("write pointer readback");
    property p_mask; io_wr && io_addr == 16'h03c6 ##2 io_rd && io_addr == 16'h03c6
        |=> io_rdata == $past(io_wdata, 3); endproperty
    a_mask: assert property (p_mask) else $error("mask readback");
endmodule // plut_access_monitor
bind plut_access plut_access_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .direct_mode(direct_mode),
    .pix_direct(pix_direct), .pix_rgb(pix_rgb));

/* File: test/plut_host.sv */
// Host processor model issuing byte I/O cycles
`timescale 1ns/1ps
module plut_host (
    // Clock
    input  wire        clk_sys,
    // Byte I/O
    output reg  [15:0] io_addr,
    output reg         io_rd,
    output reg         io_wr,
    output reg  [7:0]  io_wdata,
    input  wire [7:0]  io_rdata
);
    initial begin
        io_addr = 16'h0000;
        {io_rd, io_wr} = 2'b00;
        io_wdata = 8'h00;
    end
    // Callers send data-port bytes as whole triplets, except t_part, which cuts one after two bytes
    task wr(input [15:0] a, input [7:0] d); begin
        @(negedge clk_sys);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(negedge clk_sys);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    end endtask
    task rd(input [15:0] a, output [7:0] d); begin
        @(negedge clk_sys);
        io_addr <= a;
        io_rd <= 1'b1;
        @(negedge clk_sys);
        io_rd <= 1'b0;
        d = io_rdata;
    end endtask
endmodule // plut_host
